// ===== cfg_regs_pkg.sv
package cfg_regs_pkg;

  // direct i/o offsets (11-bit i/o address)
  localparam logic [10:0] OFS_FUNC_ENABLE  = 11'h406;
  localparam logic [10:0] OFS_EXT_STATUS   = 11'h407;
  localparam logic [10:0] OFS_CONV_DISABLE = 11'h404;
  localparam logic [10:0] OFS_BURST_ENABLE = 11'h405;
  localparam logic [10:0] OFS_INDEX_PTR    = 11'h000;
  localparam logic [10:0] OFS_INDEX_DATA   = 11'h001;

  // indexed array positions, visible while the bank bit is one
  localparam logic [7:0] IDX_GEN_CONFIG    = 8'h00;
  localparam logic [7:0] IDX_SRC_SELECT    = 8'h02;
  localparam logic [7:0] IDX_CONV_DISABLE  = 8'h40;
  localparam logic [7:0] IDX_BURST_ENABLE  = 8'h41;
  localparam logic [7:0] IDX_FUNC_ENABLE   = 8'h42;
  localparam logic [7:0] IDX_EXT_STATUS    = 8'h43;

  // magic data values of the compatibility registers
  localparam logic [7:0] VAL_ON            = 8'h40;
  localparam logic [7:0] VAL_OFF           = 8'h00;

  // reset values
  localparam logic       RST_FUNC_ENABLE   = 1'b0;
  localparam logic       RST_CONV_ALLOWED  = 1'b1;
  localparam logic       RST_BURST_ENABLE  = 1'b0;
  localparam logic       RST_AUTOINC_DIS   = 1'b0;
  localparam logic [3:0] RST_SRC_SEL       = 4'h0;
  localparam logic [7:0] RST_INDEX         = 8'h00;

  // field positions
  localparam int EXT_BURST_BIT   = 6;
  localparam int EXT_FUNC_BIT    = 5;
  localparam int EXT_CONV_BIT    = 4;
  localparam int EXT_WAIT_BIT    = 1;
  localparam int EXT_CLK_BIT     = 0;
  localparam int GEN_AUTOINC_BIT = 7;
  localparam int SEL_B_LSB       = 4;
  localparam int SEL_A_LSB       = 0;

  // event selector codes
  localparam logic [3:0] SEL_NONE       = 4'h0;
  localparam logic [3:0] SEL_RESERVED   = 4'h1;
  localparam logic [3:0] SEL_THRESHOLD  = 4'h2;
  localparam logic [3:0] SEL_FRAME_MAX  = 4'h3;
  localparam logic [3:0] SEL_TRIG_START = 4'h4;
  localparam logic [3:0] SEL_TRIG_STOP  = 4'h5;

  localparam int NUM_DIN = 4;

  // one host i/o cycle, already qualified as a single-cycle strobe
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        word;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } io_req_t;

  // events coming from the acquisition engine, single-cycle pulses
  typedef struct packed {
    logic threshold;
    logic frame_max;
    logic trig_start;
    logic trig_stop;
  } acq_evt_t;

endpackage

// ===== compat_config_irq_source_regs.sv
`timescale 1ns/1ps

// How it works
// - compatibility functions start disabled after reset.
// - enable register is write-only; 0x40 enables, 0x00 disables.
// - enable register decodes at 0x406 always, and index 0x42 when banked.
// - compatibility registers stay reachable through the indexed array.
// - extended status at 0x407 / index 0x43; bit 6 burst; 7,3,2 zero.
// - extended status bit 5 shows compatibility functions enabled.
// - extended status bit 4 shows conversions allowed, one at reset.
// - extended status bit 1 always reads zero, no wait states.
// - extended status bit 0 shows timer clock jumper, one means 10MHz.
// - general configuration at index 0x00 while banked.
// - index pointer advances by access size after each data access.
// - config bit 7 resets zero; one freezes the index pointer.
// - config bits 6:0 reflect timer clock, transfer and mode jumpers, one when installed.
// - source select at index 0x02; B in 7:4, A in 3:0.
// - selected B event sets the B flag when status bank enabled.
// - selected A event sets the A flag when status bank enabled.
// - codes 0000, 0001, 0110, 0111 select nothing; 0000 at reset.
// - 0010 threshold counter event, 0011 maximum frame count event.
// - 0100 trigger start, 0101 trigger stop transition.
// - codes 1000-1111 pick input 0-3 edges; even rising, odd falling.
// - status lower nibble shows channel or source flags per bank enable.
// - conversion disable and burst enable work only while enabled.
module compat_config_irq_source_regs
  import cfg_regs_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire io_req_t              i_io,
  input  wire logic                 i_register_bank_select,
  input  wire logic                 i_source_status_bank_enable,
  input  wire logic                 i_flag_clear,
  input  wire logic [3:0]           i_adc_channel,
  input  wire acq_evt_t             i_acq_evt,
  input  wire logic [NUM_DIN-1:0]   i_digital_input,
  input  wire logic                 i_timer_clock_jumper_state,
  input  wire logic                 i_transfer_jumper_state,
  input  wire logic [4:0]           i_mode_jumper_state,
  output logic [7:0]                o_rdata,
  output logic [7:0]                o_index,
  output logic                      o_compat_function_enable,
  output logic                      o_conversions_allowed,
  output logic                      o_burst_mode_enabled,
  output logic [3:0]                o_status_low_nibble,
  output logic                      o_source_a_flag,
  output logic                      o_source_b_flag
);

  logic [7:0]         index_r;
  logic [7:0]         index_nxt;
  logic               func_en_r;
  logic               conv_ok_r;
  logic               burst_r;
  logic               autoinc_dis_r;
  logic [3:0]         sel_a_r;
  logic [3:0]         sel_b_r;
  logic               flag_a_r;
  logic               flag_b_r;
  logic [NUM_DIN-1:0] din_meta_r;
  logic [NUM_DIN-1:0] din_sync_r;
  logic [NUM_DIN-1:0] din_prev_r;
  logic [NUM_DIN-1:0] din_rise;
  logic [NUM_DIN-1:0] din_fall;
  logic               banked;
  logic               idx_data;
  logic               hit_fe;
  logic               hit_cd;
  logic               hit_bm;
  logic               hit_es;
  logic               hit_gc;
  logic               hit_ss;
  logic [7:0]         ext_status;
  logic [7:0]         gen_config;
  logic [7:0]         rdata_nxt;
  logic               evt_a;
  logic               evt_b;
  logic               timer_fast_sel;

  // address decode; banked view is only open while the bank bit is one
  // direct offsets other than the index data port ignore the bank bit so legacy software always finds them
  assign banked   = i_register_bank_select;
  assign idx_data = banked && (i_io.addr == OFS_INDEX_DATA);
  assign hit_fe   = (i_io.addr == OFS_FUNC_ENABLE) ||
                    (idx_data && index_r == IDX_FUNC_ENABLE);
  assign hit_cd   = (i_io.addr == OFS_CONV_DISABLE) ||
                    (idx_data && index_r == IDX_CONV_DISABLE);
  assign hit_bm   = (i_io.addr == OFS_BURST_ENABLE) ||
                    (idx_data && index_r == IDX_BURST_ENABLE);
  assign hit_es   = (i_io.addr == OFS_EXT_STATUS) ||
                    (idx_data && index_r == IDX_EXT_STATUS);
  assign hit_gc   = idx_data && (index_r == IDX_GEN_CONFIG);
  assign hit_ss   = idx_data && (index_r == IDX_SRC_SELECT);

  // compatibility function enable; other values leave the state alone
  // starting disabled keeps legacy software safe until it opts in
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      func_en_r <= RST_FUNC_ENABLE;
    end else if (i_io.wr && hit_fe) begin
      if (i_io.wdata == VAL_ON) begin
        func_en_r <= 1'b1;
      end else if (i_io.wdata == VAL_OFF) begin
        func_en_r <= 1'b0;
      end
    end
  end

  // conversion disable and burst enable are ignored until enabled
  // their state is kept while the functions are switched off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      conv_ok_r <= RST_CONV_ALLOWED;
      burst_r   <= RST_BURST_ENABLE;
    end else if (i_io.wr && func_en_r) begin
      if (hit_cd && i_io.wdata == VAL_ON) begin
        conv_ok_r <= 1'b0;
      end else if (hit_cd && i_io.wdata == VAL_OFF) begin
        conv_ok_r <= 1'b1;
      end
      if (hit_bm && i_io.wdata == VAL_ON) begin
        burst_r <= 1'b1;
      end else if (hit_bm && i_io.wdata == VAL_OFF) begin
        burst_r <= 1'b0;
      end
    end
  end

  // general configuration writable bit and source selectors
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      autoinc_dis_r <= RST_AUTOINC_DIS;
      sel_a_r       <= RST_SRC_SEL;
      sel_b_r       <= RST_SRC_SEL;
    end else if (i_io.wr) begin
      if (hit_gc) begin
        autoinc_dis_r <= i_io.wdata[GEN_AUTOINC_BIT];
      end
      if (hit_ss) begin
        sel_b_r <= i_io.wdata[SEL_B_LSB +: 4];
        sel_a_r <= i_io.wdata[SEL_A_LSB +: 4];
      end
    end
  end

  // index pointer: a word access steps two, a byte access one
  // a pointer load and a data access never share one strobe
  always_comb begin
    index_nxt = index_r;
    if (i_io.wr && i_io.addr == OFS_INDEX_PTR) begin
      index_nxt = i_io.wdata;
    end else if ((i_io.wr || i_io.rd) && idx_data && !autoinc_dis_r) begin
      index_nxt = index_r + (i_io.word ? 8'h02 : 8'h01);
    end
  end

  // pointer register; o_index is loaded from the same next value
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      index_r <= RST_INDEX;
    end else begin
      index_r <= index_nxt;
    end
  end

  // the installed jumper picks the slow source, so bit 0 is its inverse
  assign timer_fast_sel = !i_timer_clock_jumper_state;

  // read-back images; bits 7, 3 and 2 stay at the zero default
  always_comb begin
    ext_status                = 8'h00;
    ext_status[EXT_BURST_BIT] = burst_r;
    ext_status[EXT_FUNC_BIT]  = func_en_r;
    ext_status[EXT_CONV_BIT]  = conv_ok_r;
    ext_status[EXT_WAIT_BIT]  = 1'b0;
    ext_status[EXT_CLK_BIT]   = timer_fast_sel;
  end

  assign gen_config = {autoinc_dis_r, i_timer_clock_jumper_state,
                       i_transfer_jumper_state, i_mode_jumper_state};

  // read mux; the enable register is write-only and reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_io.rd) begin
      if (hit_es) begin
        rdata_nxt = ext_status;
      end else if (hit_gc) begin
        rdata_nxt = gen_config;
      end else if (hit_fe) begin
        rdata_nxt = 8'h00;
      end else if (hit_ss) begin
        rdata_nxt = {sel_b_r, sel_a_r};
      end else if (i_io.addr == OFS_INDEX_PTR) begin
        rdata_nxt = index_r;
      end
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  // two-flop synchroniser, edges taken only from the second stage
  // a pulse shorter than one clock can be missed; inputs are slow levels
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      din_meta_r <= '0;
      din_sync_r <= '0;
      din_prev_r <= '0;
    end else begin
      din_meta_r <= i_digital_input;
      din_sync_r <= din_meta_r;
      din_prev_r <= din_sync_r;
    end
  end

  // one-cycle edge pulses, so one edge sets a flag only once
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIN; gi++) begin : g_edge
      assign din_rise[gi] = din_sync_r[gi] && !din_prev_r[gi];
      assign din_fall[gi] = !din_sync_r[gi] && din_prev_r[gi];
    end
  endgenerate

  // selector decode shared by both sources
  // codes 1xxx: bits 2:1 pick the input, bit 0 picks the falling edge
  function automatic logic pick(input logic [3:0] sel);
    logic r;
    r = 1'b0;
    if (sel[3]) begin
      r = sel[0] ? din_fall[sel[2:1]] : din_rise[sel[2:1]];
    end else begin
      unique case (sel)
        SEL_NONE, SEL_RESERVED: r = 1'b0;
        SEL_THRESHOLD:  r = i_acq_evt.threshold;
        SEL_FRAME_MAX:  r = i_acq_evt.frame_max;
        SEL_TRIG_START: r = i_acq_evt.trig_start;
        SEL_TRIG_STOP:  r = i_acq_evt.trig_stop;
        default:        r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // one decoder for both sources, so A and B cannot disagree
  assign evt_a = pick(sel_a_r);
  assign evt_b = pick(sel_b_r);

  // sticky flags; a new event wins over a clear in the same cycle
  // the clear arrives from a status read outside this block
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
    end else begin
      if (i_source_status_bank_enable && evt_a) begin
        flag_a_r <= 1'b1;
      end else if (i_flag_clear) begin
        flag_a_r <= 1'b0;
      end
      if (i_source_status_bank_enable && evt_b) begin
        flag_b_r <= 1'b1;
      end else if (i_flag_clear) begin
        flag_b_r <= 1'b0;
      end
    end
  end

  // registered outputs; nibble view lags its sources by one cycle
  // outputs come from flops so the host sees no decode glitches
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_index                  <= RST_INDEX;
      o_compat_function_enable <= RST_FUNC_ENABLE;
      o_conversions_allowed    <= RST_CONV_ALLOWED;
      o_burst_mode_enabled     <= RST_BURST_ENABLE;
      o_status_low_nibble      <= 4'h0;
      o_source_a_flag          <= 1'b0;
      o_source_b_flag          <= 1'b0;
    end else begin
      o_index                  <= index_nxt;
      o_compat_function_enable <= func_en_r;
      o_conversions_allowed    <= conv_ok_r;
      o_burst_mode_enabled     <= burst_r;
      o_status_low_nibble      <= i_source_status_bank_enable ?
                                  {2'b00, flag_b_r, flag_a_r} :
                                  i_adc_channel;
      o_source_a_flag          <= flag_a_r;
      o_source_b_flag          <= flag_b_r;
    end
  end

endmodule

// ===== compat_config_irq_source_regs_properties.sv
`timescale 1ns/1ps
module cfg_regs_checker
  import cfg_regs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire io_req_t    i_io,
  input  wire logic       i_register_bank_select,
  input  wire logic       i_source_status_bank_enable,
  input  wire logic [3:0] i_adc_channel,
  input  wire logic       i_timer_clock_jumper_state,
  input  wire logic [7:0] o_rdata,
  input  wire logic [7:0] o_index,
  input  wire logic       o_compat_function_enable,
  input  wire logic       o_conversions_allowed,
  input  wire logic       o_burst_mode_enabled,
  input  wire logic [3:0] o_status_low_nibble,
  input  wire logic       o_source_a_flag,
  input  wire logic       o_source_b_flag
);
  logic rd_r;
  logic st_r;
  logic bus_r;
  logic on_r;
  logic on2_r;

  // remember what was taken; answers land one or two edges later
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {rd_r, st_r, bus_r, on_r, on2_r} <= 5'h00;
    end else begin
      rd_r  <= i_io.rd;
      st_r  <= i_io.rd && (i_io.addr == OFS_EXT_STATUS);
      bus_r <= i_io.rd || i_io.wr;
      on_r  <= i_io.wr && (i_io.wdata == VAL_ON) &&
               ((i_io.addr == OFS_FUNC_ENABLE) ||
                (i_register_bank_select && i_io.addr == OFS_INDEX_DATA &&
                 o_index == IDX_FUNC_ENABLE));
      on2_r <= on_r; // enable shows two edges after the strobe
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_rdata_idle_zero: assert property (!rd_r |-> o_rdata == 8'h00)
    else $error("read data not zero without a read");
  a_ext_fixed_zero: assert property (st_r |-> !o_rdata[7] &&
    o_rdata[3:2] == 2'h0) else $error("status fixed bits not zero");
  a_ext_burst_bit: assert property (st_r |->
    o_rdata[EXT_BURST_BIT] == o_burst_mode_enabled)
    else $error("status burst bit wrong");
  a_ext_func_bit: assert property (st_r |->
    o_rdata[EXT_FUNC_BIT] == o_compat_function_enable)
    else $error("status function bit wrong");
  a_ext_conv_bit: assert property (st_r |->
    o_rdata[EXT_CONV_BIT] == o_conversions_allowed)
    else $error("status conversion bit wrong");
  a_wait_bit_zero: assert property (st_r |-> !o_rdata[EXT_WAIT_BIT])
    else $error("wait state bit set");
  a_ext_clock_bit: assert property (st_r |->
    o_rdata[EXT_CLK_BIT] == !$past(i_timer_clock_jumper_state))
    else $error("status clock bit wrong");
  a_enable_needs_write: assert property (
    $rose(o_compat_function_enable) |-> on2_r)
    else $error("functions enabled without enable write");
  a_index_holds_idle: assert property (!bus_r |-> $stable(o_index))
    else $error("index moved without access");
  a_nibble_channel: assert property (
    !$past(i_source_status_bank_enable) |->
    o_status_low_nibble == $past(i_adc_channel))
    else $error("nibble not showing channel");
  a_nibble_flags: assert property (
    $past(i_source_status_bank_enable) |->
    o_status_low_nibble == {2'b00, o_source_b_flag, o_source_a_flag})
    else $error("nibble not showing flags");
  a_flag_a_cause: assert property ($rose(o_source_a_flag) |->
    $past(i_source_status_bank_enable, 2)) else $error("flag a set while off");
  a_flag_b_cause: assert property ($rose(o_source_b_flag) |->
    $past(i_source_status_bank_enable, 2)) else $error("flag b set while off");
endmodule

bind compat_config_irq_source_regs cfg_regs_checker i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_io(i_io),
  .i_register_bank_select(i_register_bank_select),
  .i_source_status_bank_enable(i_source_status_bank_enable),
  .i_adc_channel(i_adc_channel),
  .i_timer_clock_jumper_state(i_timer_clock_jumper_state),
  .o_rdata(o_rdata), .o_index(o_index),
  .o_compat_function_enable(o_compat_function_enable),
  .o_conversions_allowed(o_conversions_allowed),
  .o_burst_mode_enabled(o_burst_mode_enabled),
  .o_status_low_nibble(o_status_low_nibble),
  .o_source_a_flag(o_source_a_flag), .o_source_b_flag(o_source_b_flag));

// ===== host_io_model.sv
`timescale 1ns/1ps
module host_io_model
  import cfg_regs_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output io_req_t         o_io
);
  initial o_io = '0;

  // one strobe cycle; the released data lines show garbage, not old data
  task automatic wr(input logic [10:0] a, input logic [7:0] v,
                    input logic w);
    @(posedge i_clk);
    #2 o_io = '{wr: 1'b1, rd: 1'b0, word: w, addr: a, wdata: v};
    @(posedge i_clk);
    #2 o_io.wr = 1'b0;
    o_io.wdata = ~v;
  endtask

  // answer stands one cycle after the strobe edge, taken right then
  task automatic rd(input logic [10:0] a, input logic w,
                    output logic [7:0] d);
    @(posedge i_clk);
    #2 o_io = '{wr: 1'b0, rd: 1'b1, word: w, addr: a, wdata: 8'h5a};
    @(posedge i_clk);
    #2 o_io.rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

// ===== compat_config_irq_source_regs_bench.sv
`timescale 1ns/1ps
module compat_config_irq_source_regs_bench;
  import cfg_regs_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  io_req_t    io;
  logic       bank = 1'b1;
  logic       en = 1'b1;
  logic       fclr = 1'b0;
  acq_evt_t   evt = '0;
  logic [3:0] din = 4'h0;
  logic       timer_clock_jumper_state = 1'b1;
  logic [3:0] chan = 4'h9;
  logic [7:0] rdata, idx, d;
  logic       fe, ca, bm, fa, fb;
  logic [3:0] nib, cc;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         cyc = 0;

  always #12.5 clk = ~clk;

  host_io_model i_host (.i_clk(clk), .i_rdata(rdata), .o_io(io));

  // mode straps stay fixed; channel and clock jumper change late in the run
  compat_config_irq_source_regs i_dut (
    .i_clk(clk), .i_rst(rst), .i_io(io), .i_register_bank_select(bank),
    .i_source_status_bank_enable(en), .i_flag_clear(fclr),
    .i_adc_channel(chan), .i_acq_evt(evt), .i_digital_input(din),
    .i_timer_clock_jumper_state(timer_clock_jumper_state), .i_transfer_jumper_state(1'b0),
    .i_mode_jumper_state(5'h15), .o_rdata(rdata), .o_index(idx),
    .o_compat_function_enable(fe), .o_conversions_allowed(ca),
    .o_burst_mode_enabled(bm), .o_status_low_nibble(nib),
    .o_source_a_flag(fa), .o_source_b_flag(fb));

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: byte %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: bit %b expected %b", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // pulse the flag clear, keeping a clean edge between drives
  task automatic clear_flags();
    repeat (6) @(posedge clk);
    #2 fclr = 1'b1;
    @(posedge clk);
    #2 fclr = 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    chk1(fe, 1'b0);
    chk1(ca, 1'b1);
    chk1(bm, 1'b0);
    i_host.rd(OFS_EXT_STATUS, 1'b0, d);
    chk8(d, 8'h10);
    i_host.wr(OFS_FUNC_ENABLE, 8'h12, 1'b0);
    i_host.wr(OFS_BURST_ENABLE, VAL_ON, 1'b0);
    i_host.rd(OFS_EXT_STATUS, 1'b0, d);
    chk8(d, 8'h10);
    i_host.wr(OFS_FUNC_ENABLE, VAL_ON, 1'b0);
    i_host.wr(OFS_BURST_ENABLE, VAL_ON, 1'b0);
    i_host.wr(OFS_CONV_DISABLE, VAL_ON, 1'b0);
    i_host.rd(OFS_EXT_STATUS, 1'b0, d);
    chk8(d, 8'h60);
    chk1(bm, 1'b1);
    chk1(ca, 1'b0);
    i_host.rd(OFS_FUNC_ENABLE, 1'b0, d);
    chk8(d, 8'h00);
    i_host.rd(11'h3ff, 1'b0, d);
    chk8(d, 8'h00);
    i_host.wr(11'h000, IDX_EXT_STATUS, 1'b0);
    i_host.rd(11'h001, 1'b0, d);
    chk8(d, 8'h60);
    chk8(idx, IDX_EXT_STATUS + 8'h01);
    i_host.wr(11'h000, IDX_FUNC_ENABLE, 1'b0);
    i_host.wr(11'h001, VAL_OFF, 1'b0);
    @(posedge clk);
    #2 chk1(fe, 1'b0);
    // general configuration: strap reflection, then the freeze bit
    i_host.wr(11'h000, IDX_GEN_CONFIG, 1'b0);
    i_host.rd(11'h001, 1'b0, d);
    chk8(d, 8'h55);
    chk8(idx, 8'h01);
    i_host.wr(11'h000, IDX_GEN_CONFIG, 1'b0);
    i_host.wr(11'h001, 8'h80, 1'b0);
    i_host.wr(11'h000, IDX_GEN_CONFIG, 1'b0);
    i_host.rd(11'h001, 1'b1, d);
    chk8(d, 8'hd5);
    chk8(idx, IDX_GEN_CONFIG);
    i_host.wr(11'h001, 8'h00, 1'b0);
    i_host.wr(11'h000, IDX_GEN_CONFIG, 1'b0);
    i_host.rd(11'h001, 1'b1, d);
    chk8(idx, 8'h02);
    bank = 1'b0;
    i_host.wr(11'h000, IDX_GEN_CONFIG, 1'b0);
    i_host.rd(11'h001, 1'b0, d);
    chk8(d, 8'h00);
    chk8(idx, IDX_GEN_CONFIG);
    bank = 1'b1;
    i_host.wr(11'h000, IDX_SRC_SELECT, 1'b0);
    i_host.wr(11'h001, 8'h3c, 1'b0);
    i_host.wr(11'h000, IDX_SRC_SELECT, 1'b0);
    i_host.rd(11'h001, 1'b0, d);
    chk8(d, 8'h3c);
    // every code on each side; the other side holds the paired code
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 16; c++) begin
        cc = c[3:0];
        i_host.wr(11'h000, IDX_SRC_SELECT, 1'b0);
        i_host.wr(11'h001, s ? {cc, cc ^ 4'h1} : {cc ^ 4'h1, cc}, 1'b0);
        din = {4{cc[0]}};
        clear_flags();
        if (cc[3]) din[cc[2:1]] = ~cc[0];
        else evt = (cc inside {[2:5]}) ? 4'h8 >> (cc - 4'h2) : 4'hf;
        @(posedge clk);
        #2 evt = '0;
        repeat (6) @(posedge clk);
        #2 chk1(s ? fb : fa,
                cc[3] || (cc inside {[2:5]}));
        chk1(s ? fa : fb, 1'b0);
      end
    end
    chk8({4'h0, nib}, 8'h02);
    // with the status bank off, a selected event leaves the flag alone
    i_host.wr(11'h000, IDX_SRC_SELECT, 1'b0);
    i_host.wr(11'h001, {4'h0, SEL_TRIG_START}, 1'b0);
    clear_flags();
    en = 1'b0;
    @(posedge clk);
    #2 evt.trig_start = 1'b1;
    @(posedge clk);
    #2 evt = '0;
    repeat (6) @(posedge clk);
    #2 chk1(fa, 1'b0);
    chk8({4'h0, nib}, 8'h09);
    chan = 4'h6;
    timer_clock_jumper_state = 1'b0;
    repeat (2) @(posedge clk);
    #2 chk8({4'h0, nib}, 8'h06);
    // the fast timer source now shows in status, the strap reads removed
    i_host.rd(OFS_EXT_STATUS, 1'b0, d);
    chk8(d, 8'h41);
    i_host.wr(11'h000, IDX_GEN_CONFIG, 1'b0);
    i_host.rd(11'h001, 1'b0, d);
    chk8(d, 8'h15);
    wrap_up();
  end
endmodule
